// *** bit_store.sv ***
// nine independent storage bits with a common clock and clear
`timescale 1ns/10ps

module bit_store
    import nine_bit_pkg::*;
(
    input wire logic clk,          // system clock
    input wire logic clr_n,        // asynchronous clear, active low
    store_if.store port            // data, strobe and held word
);

    // ------------------------------------------------------------
    // one flip-flop per line
    // ------------------------------------------------------------
    // separate 1-bit flops keep every bit a single-driver variable
    genvar i;
    generate
        for (i = 0; i < DATA_WIDTH; i++) begin : g_bit
            logic bit_reg;

            // clear wins over any load in the same cycle
            always_ff @(posedge clk or negedge clr_n) begin
                if (!clr_n) begin
                    bit_reg <= STORE_RESET[i];
                end else if (port.load) begin
                    bit_reg <= port.data[i];
                end
            end

            assign port.held[i] = bit_reg;
        end
    endgenerate

endmodule

// *** bus_far_side.sv ***
// far-side model of the shared bus lines that downstream logic sees
`timescale 1ns/10ps

module bus_far_side
    import nine_bit_pkg::*;
(
    input wire logic clk,                           // bus clock
    input wire logic [DATA_WIDTH-1:0] drive_word,   // word from the register
    input wire logic drive_en,                      // high while the register drives
    output logic [DATA_WIDTH-1:0] bus_seen          // level on the shared lines
);
    logic [DATA_WIDTH-1:0] last_reg;

    // remember the last driven word
    always_ff @(posedge clk) begin
        if (drive_en) begin
            last_reg <= drive_word;
        end
    end

    // a released bus keeps no value: show the inverse so a stale copy never passes
    assign bus_seen = drive_en ? drive_word : ~last_reg;
endmodule

// *** nine_bit_bus_register.sv ***
// nine-bit edge-triggered bus register with load enable, clear and output enable
`timescale 1ns/10ps
//
// Function
// - nine separate storage bits, one per input line, each feeding its output
// - all bits share one capture clock and one output enable
// - on a permitted rising capture edge each bit takes its input level
// - output enable low drives each output with its stored bit
// - output enable high releases all nine outputs
// - output enable never changes the stored word
// - wipe low forces all bits to zero regardless of clock, enable, data
// - new data enters storage only while wipe is high
// - wipe high and enable low loads the word at each rising capture edge
// - wipe high and enable high keeps the stored word unchanged
// - outputs carry the stored bits without inversion

module nine_bit_bus_register
    import nine_bit_pkg::*;
(
    input wire logic sys_clk,                          // system clock, 25 MHz
    input wire logic rst_n,                            // chip reset, active low
    input wire logic [DATA_WIDTH-1:0] input_bits,      // word to capture
    input wire logic capture_clock,                    // capture strobe, rising edge loads
    input wire logic load_enable_n,                    // load permitted when low
    input wire logic wipe_n,                           // clear storage when low
    input wire logic output_enable_n,                  // drive bus when low
    output logic [DATA_WIDTH-1:0] bus_outputs,         // stored word toward the bus
    output logic bus_outputs_oe                        // high while bus_outputs is driven
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [RESET_SYNC_STAGES-1:0] rst_sync_reg;
    logic rst_sync_n;

    // assert at once, release after two clean edges
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= RESET_SYNC_INIT;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], RESET_SYNC_FILL[0]};
        end
    end

    assign rst_sync_n = rst_sync_reg[RESET_SYNC_STAGES-1];

    // ------------------------------------------------------------
    // capture edge detection
    // ------------------------------------------------------------
    // capture_clock is a sampled level; the rising edge is found here
    function automatic logic rising(input logic now_level, input logic was_level);
        rising = now_level & ~was_level;
    endfunction

    edge_state_t edge_state_reg;
    edge_state_t edge_state_next;
    logic capture_edge;
    logic load_request;
    logic load_now;

    // state remembers the last sampled level of the capture strobe
    always_comb begin
        unique case (edge_state_reg)
            EDGE_IDLE: edge_state_next = capture_clock ? EDGE_HIGH : EDGE_IDLE;
            EDGE_HIGH: edge_state_next = capture_clock ? EDGE_HIGH : EDGE_IDLE;
        endcase
    end

    // starts high so a strobe already up at release is not taken as an edge
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            edge_state_reg <= CAPTURE_PREV_RESET ? EDGE_HIGH : EDGE_IDLE;
        end else begin
            edge_state_reg <= edge_state_next;
        end
    end

    // one shared edge and one shared enable steer all nine bits
    assign capture_edge = rising(capture_clock, edge_state_reg == EDGE_HIGH);
    assign load_request = capture_edge & ~load_enable_n;
    assign load_now = load_request & wipe_n;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // wipe is ored into the clear without a clock; a short low pulse
    // between edges still empties the word, at the cost of a gated reset
    store_if store_bus ();
    logic store_clr_n;

    assign store_clr_n = rst_sync_n & wipe_n;
    assign store_bus.data = input_bits;
    assign store_bus.load = load_now;

    bit_store u_store (
        .clk(sys_clk),
        .clr_n(store_clr_n),
        .port(store_bus)
    );

    // word comes straight from the storage flops
    assign bus_outputs = store_bus.held;

    // ------------------------------------------------------------
    // output enable
    // ------------------------------------------------------------
    logic oe_reg;

    // registered so the port comes from a flop; one cycle behind the pin
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            oe_reg <= OE_RESET;
        end else begin
            oe_reg <= ~output_enable_n;
        end
    end

    assign bus_outputs_oe = oe_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // a load edge with wipe high shows the sampled word a cycle later
    a_load_takes_word: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (capture_edge && !load_enable_n && wipe_n) |=>
            (!wipe_n || bus_outputs == $past(input_bits))
    ) else $error("loaded word differs from sampled input");

    // enable high blocks the load on a capture edge
    a_hold_when_off: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (capture_edge && load_enable_n && wipe_n) |=> (!wipe_n || $stable(bus_outputs))
    ) else $error("word changed with load enable high");

    // no edge, no change, whatever the data does
    a_hold_no_edge: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (!capture_edge && wipe_n) |=> (!wipe_n || $stable(bus_outputs))
    ) else $error("word changed without a capture edge");

    // wipe low shows an empty word at every edge it covers
    a_wipe_clears: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        !wipe_n |-> bus_outputs == ALL_ZERO
    ) else $error("storage not zero while wipe is low");

    // wipe beats a load requested in the same cycle
    a_wipe_priority: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (load_request && !wipe_n) |-> (bus_outputs == ALL_ZERO) ##1 (bus_outputs == ALL_ZERO)
    ) else $error("load won over wipe");

    // any change to a nonzero word needs a load a cycle before
    a_load_needs_wipe: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (bus_outputs != $past(bus_outputs) && bus_outputs != ALL_ZERO) |->
            ($past(load_request) && $past(wipe_n))
    ) else $error("word entered storage without a permitted load");

    // enable low on the pin drives the bus on the next edge
    a_oe_drives: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        !output_enable_n |=> bus_outputs_oe
    ) else $error("bus not driven with output enable low");

    // enable high on two samples in a row leaves the bus released on the next edge
    a_oe_releases: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        output_enable_n [*2] |=> !bus_outputs_oe [*1]
    ) else $error("bus driven with output enable high");

    // toggling the enable alone leaves the word alone
    a_oe_no_effect: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        ($changed(output_enable_n) && !load_now && wipe_n) |=> (!wipe_n || $stable(bus_outputs))
    ) else $error("output enable disturbed the stored word");

    // ------------------------------------------------------------
    // capture edge checks
    // ------------------------------------------------------------
    // a capture edge lasts one sample; a held strobe cannot load twice
    a_edge_one_cycle: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        capture_edge |=> !capture_edge
    ) else $error("capture edge seen on two samples in a row");

    // an edge needs the strobe low on the sample before
    a_edge_after_low: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        capture_edge |-> !$past(capture_clock)
    ) else $error("capture edge without a low strobe before it");

    // a low to high step of the strobe out of reset is never missed
    a_edge_takes_high: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (capture_clock && !$past(capture_clock) && $past(rst_sync_n)) |-> capture_edge
    ) else $error("rising strobe not taken as a capture edge");

    // the one shared detector tracks the strobe on every sample out of reset
    a_state_follows: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        $past(rst_sync_n) |-> (edge_state_reg == EDGE_HIGH) == $past(capture_clock)
    ) else $error("edge detector lost the strobe level");

    // ------------------------------------------------------------
    // storage checks
    // ------------------------------------------------------------
    // data moving under a high load enable never reaches storage
    a_hold_ignores_data: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (load_enable_n && wipe_n && $changed(input_bits)) |=> (!wipe_n || $stable(bus_outputs))
    ) else $error("word followed the data with load enable high");

    // a loaded word stands while no further edge comes
    a_load_stands: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        load_now ##1 (!capture_edge && wipe_n) |=> (!wipe_n || $stable(bus_outputs))
    ) else $error("loaded word did not stand");

    // wipe low leaves the word empty on the next sample as well
    a_wipe_holds_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        !wipe_n |=> bus_outputs == ALL_ZERO
    ) else $error("word not empty the sample after wipe");

    // a permitted edge under wipe is dropped, not kept for later
    a_wipe_drops_load: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (capture_edge && !load_enable_n && !wipe_n) ##1 wipe_n |-> bus_outputs == ALL_ZERO
    ) else $error("load under wipe reached storage");

    // lifting the wipe alone brings no data in
    a_wipe_lift_empty: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        ($rose(wipe_n) && !load_now) |=> bus_outputs == ALL_ZERO
    ) else $error("data entered storage as wipe lifted");

    // the output enable does not gate loading: a released bus still loads
    a_load_while_off: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (load_now && output_enable_n) ##1 wipe_n |-> bus_outputs == $past(input_bits)
    ) else $error("load with output enable high went wrong");

    // ------------------------------------------------------------
    // output enable checks
    // ------------------------------------------------------------
    // moving the drive flag leaves the word alone in either direction
    a_oe_edge_keeps: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        $changed(bus_outputs_oe) |-> ($stable(bus_outputs) || $past(load_now) || !wipe_n)
    ) else $error("drive flag change disturbed the word");

    // the drive flag is the pin one sample late, nothing else
    a_oe_follows: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        $past(rst_sync_n) |-> bus_outputs_oe == !$past(output_enable_n)
    ) else $error("drive flag does not follow the output enable");

    // ------------------------------------------------------------
    // reset checks
    // ------------------------------------------------------------
    // reset empties the word and releases the bus at every edge it covers
    a_reset_word: assert property (
        @(posedge sys_clk)
        !rst_sync_n |-> bus_outputs == ALL_ZERO
    ) else $error("word not empty during reset");

    a_reset_released: assert property (
        @(posedge sys_clk)
        !rst_sync_n |-> !bus_outputs_oe
    ) else $error("bus driven during reset");

    // ------------------------------------------------------------
    // per-line checks
    // ------------------------------------------------------------
    // each line moves on its own load or the wipe, never from a neighbour
    for (genvar b = 0; b < DATA_WIDTH; b++) begin : g_line_check
        a_line_cause: assert property (
            @(posedge sys_clk) disable iff (!rst_sync_n)
            $changed(bus_outputs[b]) |-> (!wipe_n || $past(load_now))
        ) else $error("output line changed without load or wipe");

        // a loaded line carries its own input level, not inverted
        a_line_copy: assert property (
            @(posedge sys_clk) disable iff (!rst_sync_n)
            load_now ##1 wipe_n |-> bus_outputs[b] == $past(input_bits[b])
        ) else $error("output line does not match its input line");

        // wipe low holds every line low
        a_line_wipe: assert property (
            @(posedge sys_clk) disable iff (!rst_sync_n)
            !wipe_n |-> !bus_outputs[b]
        ) else $error("output line high under wipe");
    end

endmodule

// *** nine_bit_bus_register_test.sv ***
// self-checking bench for the nine-bit bus register
`timescale 1ns/10ps

module nine_bit_bus_register_test;
    import nine_bit_pkg::*;
    logic sys_clk;
    logic rst_n;
    logic [DATA_WIDTH-1:0] input_bits;
    logic capture_clock;
    logic load_enable_n;
    logic wipe_n;
    logic output_enable_n;
    logic [DATA_WIDTH-1:0] bus_outputs;
    logic bus_outputs_oe;
    logic [DATA_WIDTH-1:0] bus_seen;
    logic [DATA_WIDTH-1:0] exp_word;
    logic exp_oe;
    logic cap_prev;
    logic [31:0] r;
    int bad_count;
    int checks_done;
    int seed;
    int i;

    nine_bit_bus_register dut (.sys_clk(sys_clk), .rst_n(rst_n), .input_bits(input_bits),
        .capture_clock(capture_clock), .load_enable_n(load_enable_n), .wipe_n(wipe_n),
        .output_enable_n(output_enable_n), .bus_outputs(bus_outputs), .bus_outputs_oe(bus_outputs_oe));
    bus_far_side far (.clk(sys_clk), .drive_word(bus_outputs), .drive_en(bus_outputs_oe), .bus_seen(bus_seen));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // expectation and comparison
    // ------------------------------------------------------------
    // wipe wins over a load; only a permitted rising strobe loads
    function automatic logic [DATA_WIDTH-1:0] next_word(input logic [DATA_WIDTH-1:0] cur,
        input logic [DATA_WIDTH-1:0] din, input logic rise, input logic len_n, input logic wp_n);
        if (!wp_n) return STORE_RESET;
        if (rise && !len_n) return din;
        return cur;
    endfunction

    task automatic check_word(input string what, input logic [DATA_WIDTH-1:0] exp, input logic [DATA_WIDTH-1:0] seen);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic check_flag(input string what, input logic exp, input logic seen);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %b seen %b", what, exp, seen);
        end
    endtask

    // one sample period: drive, check async wipe, then check after the edge
    task automatic step(input logic [DATA_WIDTH-1:0] din, input logic cap, input logic len_n,
        input logic wp_n, input logic oen_n);
        input_bits = din;
        capture_clock = cap;
        load_enable_n = len_n;
        wipe_n = wp_n;
        output_enable_n = oen_n;
        if (!wp_n) begin
            #1;
            check_word("wiped word", STORE_RESET, bus_outputs);
        end
        @(posedge sys_clk);
        exp_word = next_word(exp_word, din, cap && !cap_prev, len_n, wp_n);
        cap_prev = cap;
        exp_oe = !oen_n;
        #2;
        check_word("stored word", exp_word, bus_outputs);
        check_flag("drive enable", exp_oe, bus_outputs_oe);
        if (exp_oe) begin
            check_word("bus level", exp_word, bus_seen);
        end
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h9e624064;
        bad_count = 0;
        checks_done = 0;
        rst_n = 1'b0;
        input_bits = ALL_ZERO;
        capture_clock = 1'b0;
        load_enable_n = 1'b1;
        wipe_n = 1'b1;
        output_enable_n = 1'b1;
        exp_word = STORE_RESET;
        exp_oe = 1'b0;
        cap_prev = 1'b1;
        repeat (12) @(posedge sys_clk);
        #2 rst_n = 1'b1;
        repeat (2) @(posedge sys_clk);
        #2;
        check_word("reset word", STORE_RESET, bus_outputs);
        step(ALL_ZERO, 1'b0, 1'b1, 1'b1, 1'b1);
        // held strobe loads once, then enable high blocks a new edge
        step(9'h1A5, 1'b1, 1'b0, 1'b1, 1'b0);
        step(9'h05A, 1'b1, 1'b0, 1'b1, 1'b0);
        step(9'h0FF, 1'b0, 1'b0, 1'b1, 1'b1);
        step(9'h1FF, 1'b1, 1'b1, 1'b1, 1'b0);
        // all ones then all zero, driven and released
        step(9'h1FF, 1'b0, 1'b0, 1'b1, 1'b0);
        step(9'h1FF, 1'b1, 1'b0, 1'b1, 1'b0);
        step(9'h000, 1'b0, 1'b0, 1'b1, 1'b0);
        step(9'h000, 1'b1, 1'b0, 1'b1, 1'b1);
        // wipe in the same sample as a load request
        step(9'h0AA, 1'b0, 1'b0, 1'b1, 1'b0);
        step(9'h155, 1'b1, 1'b0, 1'b1, 1'b0);
        step(9'h0AA, 1'b0, 1'b0, 1'b1, 1'b0);
        step(9'h0AA, 1'b1, 1'b0, 1'b0, 1'b0);
        step(9'h0AA, 1'b0, 1'b0, 1'b1, 1'b0);
        // random traffic: wipe one time in eight, enable high one in four
        for (i = 0; i < 600; i++) begin
            r = $random(seed);
            step(r[8:0], r[9], r[10] & r[11], |r[14:12], r[15]);
        end
        // second reset in mid-run, strobe already high at release: no false edge
        rst_n = 1'b0;
        capture_clock = 1'b1;
        load_enable_n = 1'b0;
        wipe_n = 1'b1;
        output_enable_n = 1'b1;
        input_bits = 9'h1C3;
        #1;
        check_word("reset word", STORE_RESET, bus_outputs);
        check_flag("reset drive enable", 1'b0, bus_outputs_oe);
        repeat (3) @(posedge sys_clk);
        #2 rst_n = 1'b1;
        repeat (2) @(posedge sys_clk);
        #2;
        exp_word = STORE_RESET;
        cap_prev = 1'b1;
        step(9'h1C3, 1'b1, 1'b0, 1'b1, 1'b0);
        step(9'h1C3, 1'b0, 1'b0, 1'b1, 1'b0);
        step(9'h1C3, 1'b1, 1'b0, 1'b1, 1'b0);
        test_done;
    end

    // hang guard, well past the sample periods above
    initial begin
        #(40 * 2000);
        bad_count++;
        test_done;
    end
endmodule

// *** nine_bit_pkg.sv ***
// constants shared by the nine-bit bus register and its storage slice
package nine_bit_pkg;

    // ------------------------------------------------------------
    // word layout
    // ------------------------------------------------------------
    localparam int DATA_WIDTH = 9;                        // bits held and driven
    localparam logic [8:0] STORE_RESET = 9'h000;          // storage after clear
    localparam logic [8:0] ALL_ZERO = 9'h000;             // reference for checks

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    localparam int RESET_SYNC_STAGES = 2;                 // depth of release chain
    localparam logic [1:0] RESET_SYNC_INIT = 2'h0;        // chain value in reset
    localparam logic [1:0] RESET_SYNC_FILL = 2'h1;        // bit shifted in on release

    // ------------------------------------------------------------
    // capture edge detector and output enable
    // ------------------------------------------------------------
    localparam logic CAPTURE_PREV_RESET = 1'h1;           // no false edge at release
    localparam logic OE_RESET = 1'h0;                     // outputs released in reset

    // capture edge decoder states
    typedef enum logic [0:0] {
        EDGE_IDLE,
        EDGE_HIGH
    } edge_state_t;

endpackage

// *** store_if.sv ***
// bundle between the register top and its storage slice
`timescale 1ns/10ps

interface store_if;
    import nine_bit_pkg::*;

    logic [DATA_WIDTH-1:0] data;   // word presented for loading
    logic load;                    // one-cycle load strobe
    logic [DATA_WIDTH-1:0] held;   // current stored word

    // control side drives data and strobe, reads the word back
    modport ctrl (
        output data,
        output load,
        input held
    );

    // storage side takes data and strobe, shows its word
    modport store (
        input data,
        input load,
        output held
    );

endinterface
